// ==== port_pin_pkg.sv ====
package port_pin_pkg;

    // ********************************
    // Register map
    // ********************************
    localparam int ADDR_W = 9;
    localparam logic [8:0] OFF_PIN_LEVEL_A = 9'h005;
    localparam logic [8:0] OFF_PIN_LEVEL_B = 9'h006;
    localparam logic [8:0] OFF_PIN_LEVEL_C = 9'h007;
    localparam logic [8:0] OFF_INTERRUPT_CONTROL = 9'h00B;
    localparam logic [8:0] OFF_OPTION_CONTROL = 9'h081;
    localparam logic [8:0] OFF_DIRECTION_A = 9'h085;
    localparam logic [8:0] OFF_DIRECTION_B = 9'h086;
    localparam logic [8:0] OFF_DIRECTION_C = 9'h087;
    localparam logic [8:0] OFF_PULLUP_ENABLE_A = 9'h095;
    localparam logic [8:0] OFF_CHANGE_INT_ENABLE_A = 9'h096;
    localparam logic [8:0] OFF_PULLUP_ENABLE_B = 9'h115;
    localparam logic [8:0] OFF_CHANGE_INT_ENABLE_B = 9'h116;
    localparam logic [8:0] OFF_ANALOG_SELECT_LOW = 9'h11E;
    localparam logic [8:0] OFF_ANALOG_SELECT_HIGH = 9'h11F;
    localparam logic [8:0] OFF_PIN_FUNC_C = 9'h19D;
    localparam logic [8:0] OFF_BIT_MODIFY_A = 9'h1A5;

    // ********************************
    // Field positions
    // ********************************
    localparam int FLAG_BIT = 0;
    localparam int WAKE_EN_BIT = 3;
    localparam int GLOBAL_PU_DIS_BIT = 7;
    localparam int PB7_BIT = 7;
    localparam int PC4_BIT = 4;
    localparam int PC5_BIT = 5;
    localparam int MASTER_CLEAR_INPUT_PIN = 3;
    localparam int FUNC4_LSB = 0;
    localparam int FUNC5_LSB = 2;
    localparam int BITOP_VAL_BIT = 3;

    // ********************************
    // Reset values
    // ********************************
    localparam logic [7:0] RST_DIRECTION = 8'hFF;
    localparam logic [7:0] RST_OPTION = 8'h80;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // Pin function of a shared port C pin
    typedef enum logic [1:0] {PF_GPIO, PF_PERIPH, PF_PWM, PF_SPARE} pin_func_e;

    // One-hot mask from a bit index
    function automatic logic [7:0] bit_mask(input logic [2:0] idx);
        bit_mask = 8'h01 << idx;
    endfunction : bit_mask

endpackage : port_pin_pkg

// ==== change_detect.sv ====
module change_detect
    import port_pin_pkg::*;
#(
    parameter int WIDTH = 7
) (
    // Clock and power-on reset only
    input wire logic clk,
    input wire logic rst_n,
    // Pin levels and controls
    input wire logic [WIDTH-1:0] level,
    input wire logic [WIDTH-1:0] enable,
    input wire logic [WIDTH-1:0] reload,
    // Any enabled pin differs from its latch
    output logic mismatch
);

    typedef struct packed {
        logic [WIDTH-1:0] seen;
    } cd_state_s;

    cd_state_s st_r;
    cd_state_s st_nxt;
    logic [WIDTH-1:0] diff;

    // Per-pin compare against last-read value
    for (genvar i = 0; i < WIDTH; i++) begin : g_cmp
        assign diff[i] = enable[i] & (level[i] ^ st_r.seen[i]); // R9
    end
    assign mismatch = |diff; // R9

    // Reload takes the level of the access cycle itself
    always_comb begin
        st_nxt = st_r;
        for (int i = 0; i < WIDTH; i++) begin
            if (reload[i]) begin
                st_nxt.seen[i] = level[i]; // R10 R13
            end
        end
    end

    // Only power-on clears it; warm resets never reach here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt; // R12
        end
    end

endmodule : change_detect

// ==== pin_mux_c.sv ====
module pin_mux_c
    import port_pin_pkg::*;
(
    // Function selects
    input wire pin_func_e func4,
    input wire pin_func_e func5,
    // Port C latch, direction and pins (bit 0 is pin four)
    input wire logic [1:0] lat,
    input wire logic [1:0] dir,
    input wire logic [1:0] pin_in,
    // Peripheral sources
    input wire logic comparator2_output,
    input wire logic pwm_output_a,
    input wire logic pwm_output_b,
    input wire logic ccp_out,
    input wire logic ccp_oe,
    // Muxed pin drive
    output logic [1:0] out,
    output logic [1:0] oe,
    output logic ccp_in
);

    // Pin four: I/O, comparator output or second PWM output
    always_comb begin
        oe[0] = ~dir[0];
        case (func4)
            PF_PERIPH: out[0] = comparator2_output; // R16
            PF_PWM: out[0] = pwm_output_b; // R16
            default: out[0] = lat[0];
        endcase
    end

    // Pin five: I/O, capture/compare pin or first PWM output
    always_comb begin
        oe[1] = ~dir[1];
        case (func5)
            PF_PERIPH: begin
                out[1] = ccp_out; // R18
                oe[1] = ~dir[1] & ccp_oe; // R18
            end
            PF_PWM: out[1] = pwm_output_a; // R18
            default: out[1] = lat[1];
        endcase
    end

    // Capture input sees the pin whatever the function
    assign ccp_in = pin_in[1]; // R18

endmodule : pin_mux_c

// ==== port_pin_features.sv ====
// Operation
// R1 - Analog-selected pins read zero digitally; analog function stays enabled.
// R2 - Analog select never blocks the digital output driver.
// R3 - Bit modify reads pins, so analog pins write zero into latch.
// R4 - Every port A pin but master clear pin has its pull-up enable.
// R5 - Pull-up is off whenever the pin is an output.
// R6 - Power-on reset sets the global pull-up disable.
// R7 - Master clear pin pull-up follows master clear mode only.
// R8 - Per-pin change enables, all cleared at power-on.
// R9 - Enabled pins compared with last-read latch; mismatches OR into flag.
// R10 - Port access reloads latch; ongoing mismatch keeps setting the flag.
// R11 - Software ends the mismatch first, then clears the flag.
// R12 - Warm resets keep the latch; mismatch still sets the flag.
// R13 - Change in the read cycle itself may be absorbed.
// R14 - Pin-change flag can wake the device.
// R15 - Port B pin seven has its own change enable and pull-up.
// R16 - Port C pin four: I/O, comparator output or second PWM.
// R17 - Software never enables comparator and second PWM outputs together.
// R18 - Port C pin five: I/O, capture/compare pin or first PWM.
// R19 - Flag sticks until cleared; clear lost while a mismatch exists.
//
// Implementation choice: strobed register access.
module port_pin_features
    import port_pin_pkg::*;
#(
    parameter int PA_W = 6
) (
    // Clock and resets
    input wire logic clk,
    input wire logic rst_n,
    input wire logic master_clear_input,
    input wire logic brownout_reset,
    input wire logic master_clear_input_enable,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Port A pins
    input wire logic [PA_W-1:0] pa_in,
    output logic [PA_W-1:0] pa_out,
    output logic [PA_W-1:0] pa_oe,
    output logic [PA_W-1:0] pa_pullup,
    // Port B pin seven
    input wire logic pb7_in,
    output logic pb7_out,
    output logic pb7_oe,
    output logic pb7_pullup,
    // Port C pins four and five
    input wire logic [1:0] pc_in,
    output logic [1:0] pc_out,
    output logic [1:0] pc_oe,
    // Peripheral hookup
    input wire logic comparator2_output,
    input wire logic pwm_output_a,
    input wire logic pwm_output_b,
    input wire logic capture_compare_pin_out,
    input wire logic capture_compare_pin_oe,
    output logic capture_compare_pin_in,
    // Analog enables and wake
    output logic [15:0] analog_enable,
    output logic wake
);

    // ********************************
    // Parameter check
    // ********************************
    if (PA_W <= MASTER_CLEAR_INPUT_PIN || PA_W > 8) begin : g_bad_width
        $error("PA_W must lie above the master clear pin and be at most 8");
    end

    localparam logic [PA_W-1:0] MASTER_CLEAR_INPUT_MASK = PA_W'(1) << MASTER_CLEAR_INPUT_PIN;
    localparam int CD_W = PA_W + 1;

    // ********************************
    // State
    // ********************************
    typedef struct packed {
        logic [7:0] lat_a;
        logic [7:0] lat_b;
        logic [7:0] lat_c;
        logic [7:0] dir_a;
        logic [7:0] dir_b;
        logic [7:0] dir_c;
        logic [7:0] wpu_a;
        logic [7:0] wpu_b;
        logic [7:0] ioc_a;
        logic [7:0] ioc_b;
        logic [7:0] ans_lo;
        logic [7:0] ans_hi;
        logic [7:0] option;
        logic [7:0] func_c;
        logic flag;
        logic wake_en;
        logic [7:0] rdata;
        logic [PA_W-1:0] pa_out;
        logic [PA_W-1:0] pa_oe;
        logic [PA_W-1:0] pa_pu;
        logic pb7_out;
        logic pb7_oe;
        logic pb7_pu;
        logic [1:0] pc_out;
        logic [1:0] pc_oe;
        logic ccp_in;
        logic [15:0] ana;
        logic wake;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    // Configuration defaults shared by power-on and warm resets
    function automatic state_s init_regs(input state_s s);
        state_s r;
        r = s;
        r.dir_a = RST_DIRECTION;
        r.dir_b = RST_DIRECTION;
        r.dir_c = RST_DIRECTION;
        r.wpu_a = RST_ZERO;
        r.wpu_b = RST_ZERO;
        r.ioc_a = RST_ZERO; // R8
        r.ioc_b = RST_ZERO; // R8
        r.ans_lo = RST_ZERO;
        r.ans_hi = RST_ZERO;
        r.option = RST_OPTION; // R6
        r.func_c = RST_ZERO;
        r.wake_en = 1'b0;
        r.flag = 1'b0;
        init_regs = r;
    endfunction : init_regs

    // ********************************
    // Reset release
    // ********************************
    logic [1:0] rst_pipe_r;
    logic rst_sync_n;

    // Two stages against metastable release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_r <= 2'b00;
        end else begin
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe_r[1];

    // ********************************
    // Decode and pin views
    // ********************************
    logic warm;
    logic acc_a;
    logic acc_b;
    logic bitop_wr;
    logic interrupt_control_wr;
    logic interrupt_control_clr;
    logic sw_set;
    logic mismatch;
    logic [7:0] rd_a;
    logic [7:0] rd_b;
    logic [7:0] rd_c;
    logic [7:0] rd_val;
    logic [7:0] bitop_mask;
    logic [CD_W-1:0] cd_level;
    logic [CD_W-1:0] cd_enable;
    logic [CD_W-1:0] cd_reload;
    logic [1:0] mux_out;
    logic [1:0] mux_oe;
    logic mux_ccp_in;

    assign warm = master_clear_input | brownout_reset;
    assign acc_a = (rd | wr) && (addr == OFF_PIN_LEVEL_A);
    assign acc_b = (rd | wr) && (addr == OFF_PIN_LEVEL_B);
    assign bitop_wr = wr && (addr == OFF_BIT_MODIFY_A);
    assign interrupt_control_wr = wr && (addr == OFF_INTERRUPT_CONTROL);
    assign interrupt_control_clr = interrupt_control_wr && !wdata[FLAG_BIT];
    assign sw_set = interrupt_control_wr && wdata[FLAG_BIT];
    assign bitop_mask = bit_mask(wdata[2:0]);

    // Digital reads: analog-selected pins give zero
    assign rd_a = 8'(pa_in & ~st_r.ans_lo[PA_W-1:0]); // R1
    assign rd_b = {pb7_in, 7'h00};
    assign rd_c = {2'b00, pc_in, 4'h0};

    // Change detectors: port A pins plus port B pin seven
    assign cd_level = {pb7_in, rd_a[PA_W-1:0]};
    assign cd_enable = {st_r.ioc_b[PB7_BIT], st_r.ioc_a[PA_W-1:0]}; // R8 R15
    assign cd_reload = {acc_b, {PA_W{acc_a | bitop_wr}}}; // R10

    change_detect #(
        .WIDTH(CD_W)
    ) u_change_detect (
        .clk(clk),
        .rst_n(rst_sync_n),
        .level(cd_level),
        .enable(cd_enable),
        .reload(cd_reload),
        .mismatch(mismatch)
    );

    pin_mux_c u_pin_mux_c (
        .func4(pin_func_e'(st_r.func_c[FUNC4_LSB +: 2])),
        .func5(pin_func_e'(st_r.func_c[FUNC5_LSB +: 2])),
        .lat({st_r.lat_c[PC5_BIT], st_r.lat_c[PC4_BIT]}),
        .dir({st_r.dir_c[PC5_BIT], st_r.dir_c[PC4_BIT]}),
        .pin_in(pc_in),
        .comparator2_output(comparator2_output),
        .pwm_output_a(pwm_output_a),
        .pwm_output_b(pwm_output_b),
        .ccp_out(capture_compare_pin_out),
        .ccp_oe(capture_compare_pin_oe),
        .out(mux_out),
        .oe(mux_oe),
        .ccp_in(mux_ccp_in)
    );

    // ********************************
    // Read mux
    // ********************************
    always_comb begin
        rd_val = 8'h00;
        if (addr == OFF_PIN_LEVEL_A) begin
            rd_val = rd_a; // R1
        end else if (addr == OFF_PIN_LEVEL_B) begin
            rd_val = rd_b;
        end else if (addr == OFF_PIN_LEVEL_C) begin
            rd_val = rd_c;
        end else if (addr == OFF_INTERRUPT_CONTROL) begin
            rd_val[FLAG_BIT] = st_r.flag;
            rd_val[WAKE_EN_BIT] = st_r.wake_en;
        end else if (addr == OFF_OPTION_CONTROL) begin
            rd_val = st_r.option;
        end else if (addr == OFF_DIRECTION_A) begin
            rd_val = st_r.dir_a;
        end else if (addr == OFF_DIRECTION_B) begin
            rd_val = st_r.dir_b;
        end else if (addr == OFF_DIRECTION_C) begin
            rd_val = st_r.dir_c;
        end else if (addr == OFF_PULLUP_ENABLE_A) begin
            rd_val = st_r.wpu_a;
        end else if (addr == OFF_CHANGE_INT_ENABLE_A) begin
            rd_val = st_r.ioc_a;
        end else if (addr == OFF_PULLUP_ENABLE_B) begin
            rd_val = st_r.wpu_b;
        end else if (addr == OFF_CHANGE_INT_ENABLE_B) begin
            rd_val = st_r.ioc_b;
        end else if (addr == OFF_ANALOG_SELECT_LOW) begin
            rd_val = st_r.ans_lo;
        end else if (addr == OFF_ANALOG_SELECT_HIGH) begin
            rd_val = st_r.ans_hi;
        end else if (addr == OFF_PIN_FUNC_C) begin
            rd_val = st_r.func_c;
        end
    end

    // ********************************
    // Next state
    // ********************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = rd ? rd_val : 8'h00;
        // Register writes
        if (wr) begin
            if (addr == OFF_PIN_LEVEL_A) begin
                st_nxt.lat_a = wdata;
            end else if (addr == OFF_PIN_LEVEL_B) begin
                st_nxt.lat_b = wdata;
            end else if (addr == OFF_PIN_LEVEL_C) begin
                st_nxt.lat_c = wdata;
            end else if (addr == OFF_OPTION_CONTROL) begin
                st_nxt.option = wdata;
            end else if (addr == OFF_DIRECTION_A) begin
                st_nxt.dir_a = wdata;
            end else if (addr == OFF_DIRECTION_B) begin
                st_nxt.dir_b = wdata;
            end else if (addr == OFF_DIRECTION_C) begin
                st_nxt.dir_c = wdata;
            end else if (addr == OFF_PULLUP_ENABLE_A) begin
                st_nxt.wpu_a = wdata; // R4
            end else if (addr == OFF_CHANGE_INT_ENABLE_A) begin
                st_nxt.ioc_a = wdata; // R8
            end else if (addr == OFF_PULLUP_ENABLE_B) begin
                st_nxt.wpu_b = wdata; // R15
            end else if (addr == OFF_CHANGE_INT_ENABLE_B) begin
                st_nxt.ioc_b = wdata; // R15
            end else if (addr == OFF_ANALOG_SELECT_LOW) begin
                st_nxt.ans_lo = wdata;
            end else if (addr == OFF_ANALOG_SELECT_HIGH) begin
                st_nxt.ans_hi = wdata;
            end else if (addr == OFF_PIN_FUNC_C) begin
                st_nxt.func_c = wdata;
            end else if (addr == OFF_INTERRUPT_CONTROL) begin
                st_nxt.wake_en = wdata[WAKE_EN_BIT];
            end else if (addr == OFF_BIT_MODIFY_A) begin
                // Base is the pin view, so analog pins come back as zero
                st_nxt.lat_a = (rd_a & ~bitop_mask) // R3
                    | (wdata[BITOP_VAL_BIT] ? bitop_mask : 8'h00); // R3
            end
        end
        // Flag: set beats clear, so a live mismatch blocks the clear
        if (mismatch || sw_set) begin
            st_nxt.flag = 1'b1; // R9 R10 R19
        end else if (interrupt_control_clr) begin
            st_nxt.flag = 1'b0; // R19
        end
        // Warm reset: config back to defaults, latch kept by detector
        if (warm) begin
            st_nxt = init_regs(st_nxt);
            st_nxt.flag = mismatch; // R12
        end
        // Port A drive; analog select plays no part here
        st_nxt.pa_out = st_r.lat_a[PA_W-1:0]; // R2
        st_nxt.pa_oe = ~st_r.dir_a[PA_W-1:0] & ~MASTER_CLEAR_INPUT_MASK; // R2
        for (int i = 0; i < PA_W; i++) begin
            if (i == MASTER_CLEAR_INPUT_PIN) begin
                st_nxt.pa_pu[i] = master_clear_input_enable; // R7
            end else begin
                st_nxt.pa_pu[i] = st_r.wpu_a[i] & st_r.dir_a[i] // R4 R5
                    & ~st_r.option[GLOBAL_PU_DIS_BIT]; // R6
            end
        end
        // Port B pin seven, same scheme as port A
        st_nxt.pb7_out = st_r.lat_b[PB7_BIT];
        st_nxt.pb7_oe = ~st_r.dir_b[PB7_BIT];
        st_nxt.pb7_pu = st_r.wpu_b[PB7_BIT] & st_r.dir_b[PB7_BIT] // R15 R5
            & ~st_r.option[GLOBAL_PU_DIS_BIT]; // R6
        // Port C shared pins
        st_nxt.pc_out = mux_out; // R16 R18
        st_nxt.pc_oe = mux_oe;
        st_nxt.ccp_in = mux_ccp_in;
        st_nxt.ana = {st_r.ans_hi, st_r.ans_lo}; // R1
        st_nxt.wake = st_r.flag & st_r.wake_en; // R14
    end

    // Single state register
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_r <= init_regs('0);
        end else begin
            st_r <= st_nxt;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    assign rdata = st_r.rdata;
    assign pa_out = st_r.pa_out;
    assign pa_oe = st_r.pa_oe;
    assign pa_pullup = st_r.pa_pu;
    assign pb7_out = st_r.pb7_out;
    assign pb7_oe = st_r.pb7_oe;
    assign pb7_pullup = st_r.pb7_pu;
    assign pc_out = st_r.pc_out;
    assign pc_oe = st_r.pc_oe;
    assign capture_compare_pin_in = st_r.ccp_in;
    assign analog_enable = st_r.ana;
    assign wake = st_r.wake;

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_sync_n);

    property p_analog_read_zero;
        rd && addr == OFF_PIN_LEVEL_A |=>
            (rdata[PA_W-1:0] & $past(st_r.ans_lo[PA_W-1:0])) == '0;
    endproperty
    a_analog_read_zero: assert property (p_analog_read_zero) // R1
        else $error("analog pin read back non-zero");

    property p_output_path;
        ##1 pa_out == $past(st_r.lat_a[PA_W-1:0])
            && pa_oe == ($past(~st_r.dir_a[PA_W-1:0]) & ~MASTER_CLEAR_INPUT_MASK);
    endproperty
    a_output_path: assert property (p_output_path) // R2
        else $error("port A drive does not follow latch and direction");

    property p_bitop_zero;
        bitop_wr && !warm |=> (st_r.lat_a & $past(st_r.ans_lo)
            & ~bit_mask($past(wdata[2:0]))) == 8'h00;
    endproperty
    a_bitop_zero: assert property (p_bitop_zero) // R3
        else $error("bit modify kept a latch bit of an analog pin");

    property p_pullup_output_off;
        ##1 (pa_pullup & ~$past(st_r.dir_a[PA_W-1:0]) & ~MASTER_CLEAR_INPUT_MASK) == '0;
    endproperty
    a_pullup_output_off: assert property (p_pullup_output_off) // R5
        else $error("pull-up on while pin is an output");

    property p_global_disable;
        st_r.option[GLOBAL_PU_DIS_BIT] |=>
            (pa_pullup & ~MASTER_CLEAR_INPUT_MASK) == '0 && !pb7_pullup;
    endproperty
    a_global_disable: assert property (p_global_disable) // R6
        else $error("pull-up on under global disable");

    property p_master_clear_input_pullup;
        ##1 pa_pullup[MASTER_CLEAR_INPUT_PIN] == $past(master_clear_input_enable);
    endproperty
    a_master_clear_input_pullup: assert property (p_master_clear_input_pullup) // R7
        else $error("master clear pin pull-up wrong");

    property p_no_enable_no_flag;
        !st_r.flag && st_r.ioc_a == 8'h00 && !st_r.ioc_b[PB7_BIT] && !sw_set
            |=> !st_r.flag;
    endproperty
    a_no_enable_no_flag: assert property (p_no_enable_no_flag) // R8
        else $error("flag set with every detector disabled");

    property p_mismatch_sets;
        mismatch |=> st_r.flag;
    endproperty
    a_mismatch_sets: assert property (p_mismatch_sets) // R9
        else $error("mismatch did not set the flag");

    property p_clear_blocked;
        st_r.flag && mismatch && interrupt_control_clr |=> st_r.flag [*1] ##1 1'b1;
    endproperty
    a_clear_blocked: assert property (p_clear_blocked) // R10
        else $error("flag cleared while mismatch persisted");

    property p_warm_keeps;
        warm && mismatch |=> st_r.flag && st_r.dir_a == RST_DIRECTION;
    endproperty
    a_warm_keeps: assert property (p_warm_keeps) // R12
        else $error("warm reset lost the pending change");

    property p_wake;
        ##2 wake == $past(st_r.flag && st_r.wake_en, 1);
    endproperty
    a_wake: assert property (p_wake) // R14
        else $error("wake does not follow the enabled flag");

    property p_pin_four_comp;
        pin_func_e'(st_r.func_c[FUNC4_LSB +: 2]) == PF_PERIPH
            |=> pc_out[0] == $past(comparator2_output);
    endproperty
    a_pin_four_comp: assert property (p_pin_four_comp) // R16
        else $error("pin four not carrying the comparator output");

    property p_pin_five_pwm;
        pin_func_e'(st_r.func_c[FUNC5_LSB +: 2]) == PF_PWM
            |=> pc_out[1] == $past(pwm_output_a);
    endproperty
    a_pin_five_pwm: assert property (p_pin_five_pwm) // R18
        else $error("pin five not carrying the first PWM output");

    property p_flag_sticks;
        st_r.flag && !interrupt_control_clr && !warm |=> st_r.flag;
    endproperty
    a_flag_sticks: assert property (p_flag_sticks) // R19
        else $error("flag dropped without a clear");

    // Main scenarios
    c_flag_set: cover property (!st_r.flag ##1 st_r.flag);
    c_clear_after_read: cover property (acc_a ##1 interrupt_control_clr ##1 !st_r.flag);
    c_warm_pending: cover property (warm && mismatch);
    c_pin_four_pwm: cover property (pin_func_e'(st_r.func_c[FUNC4_LSB +: 2]) == PF_PWM);

endmodule : port_pin_features

// ==== pin_board.sv ====
module pin_board #(
    parameter int W = 6
) (
    // Device drive
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] oe,
    input wire logic [W-1:0] pu_on,
    // Board sources
    input wire logic [W-1:0] ext,
    input wire logic [W-1:0] ext_en,
    output logic [W-1:0] level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Driver, then board, then pull-up; a bare float reads the inverse
    assign level = (oe & out) | (~oe & ext_en & ext) | (~oe & ~ext_en & (pu_on | ~out));
endmodule : pin_board

// ==== port_pin_features_tb.sv ====
module port_pin_features_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import port_pin_pkg::*;
    typedef struct packed {logic [8:0] a; logic [7:0] v;} row_s;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic mcl = 1'h0, mce = 1'h0, wr = 1'h0, rd = 1'h0;
    logic cmp = 1'h0, pwa = 1'h0, pwb = 1'h0, cco = 1'h0, wake;
    logic bor = 1'h0, pb7 = 1'h0;
    logic [15:0] ana;
    logic [8:0] addr = 9'h000;
    logic [7:0] wdata = 8'h00, rdata, rv;
    logic [5:0] ext = 6'h15, pa_in, pa_out, pa_oe, pa_pu;
    logic [1:0] pc_out;
    int failures = 0, samples_checked = 0, cyc = 0;
    // Reset values; the last row is an unmapped place
    row_s rows [7] = '{'{OFF_OPTION_CONTROL, RST_OPTION}, '{OFF_PULLUP_ENABLE_A, 8'h00},
        '{OFF_CHANGE_INT_ENABLE_A, 8'h00}, '{OFF_ANALOG_SELECT_LOW, 8'h00},
        '{OFF_ANALOG_SELECT_HIGH, 8'h00}, '{OFF_INTERRUPT_CONTROL, 8'h00}, '{9'h0FF, 8'h00}};
    port_pin_features #(.PA_W(6)) i_dut (
        .clk(clk), .rst_n(rst_n), .master_clear_input(mcl), .brownout_reset(bor),
        .master_clear_input_enable(mce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pa_pullup(pa_pu), .pb7_in(pb7),
        .pb7_out(), .pb7_oe(), .pb7_pullup(), .pc_in(2'h0), .pc_out(pc_out), .pc_oe(),
        .comparator2_output(cmp), .pwm_output_a(pwa), .pwm_output_b(pwb),
        .capture_compare_pin_out(cco), .capture_compare_pin_oe(1'h1),
        .capture_compare_pin_in(), .analog_enable(ana), .wake(wake));
    pin_board #(.W(6)) i_board (.out(pa_out), .oe(pa_oe), .pu_on(pa_pu), .ext(ext),
        .ext_en(6'h3F), .level(pa_in));
    initial forever #2 clk = ~clk;
    // Hang guard, run needs about 110 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            end_sim;
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wreg(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'h0;
    endtask : wreg
    task automatic rreg(input logic [8:0] a);
        @(posedge clk);
        rd <= 1'h1;
        addr <= a;
        @(posedge clk);
        rd <= 1'h0;
        #1 rv = rdata;
    endtask : rreg
    // Outputs lag the register by one flop
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle
    task automatic end_sim;
        if (failures == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    // ****************
    // Main sequence
    // ****************
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk);
        #1;
        check(8'(pa_pu), 8'h00);
        foreach (rows[i]) begin
            rreg(rows[i].a);
            check(rv, rows[i].v);
        end
        wreg(OFF_OPTION_CONTROL, 8'h00);
        wreg(OFF_PULLUP_ENABLE_A, 8'h3F);
        settle;
        check(8'(pa_pu), 8'h37);
        @(posedge clk) mce <= 1'h1;
        wreg(OFF_DIRECTION_A, 8'h3E);
        settle;
        check(8'(pa_pu), 8'h3E);
        // Pin zero drives high yet reads zero as analog
        wreg(OFF_PIN_LEVEL_A, 8'h01);
        wreg(OFF_ANALOG_SELECT_LOW, 8'h01);
        settle;
        check(8'(pa_out & pa_oe), 8'h01);
        check(ana[7:0], 8'h01);
        rreg(OFF_PIN_LEVEL_A);
        check(rv, 8'h14);
        wreg(OFF_BIT_MODIFY_A, 8'h09);
        settle;
        check(8'(pa_out & pa_oe), 8'h00);
        // Change flag: clear refused until the mismatch ends
        rreg(OFF_PIN_LEVEL_A);
        wreg(OFF_CHANGE_INT_ENABLE_A, 8'h02);
        wreg(OFF_INTERRUPT_CONTROL, 8'h08);
        @(posedge clk) ext <= 6'h17;
        settle;
        rreg(OFF_INTERRUPT_CONTROL);
        check(rv, 8'h09);
        check(8'(wake), 8'h01);
        wreg(OFF_INTERRUPT_CONTROL, 8'h08);
        rreg(OFF_INTERRUPT_CONTROL);
        check(rv, 8'h09);
        rreg(OFF_PIN_LEVEL_A);
        wreg(OFF_INTERRUPT_CONTROL, 8'h08);
        rreg(OFF_INTERRUPT_CONTROL);
        check(rv, 8'h08);
        // Warm reset keeps latch high; pin still high so no flag
        @(posedge clk) mcl <= 1'h1;
        @(posedge clk) mcl <= 1'h0;
        wreg(OFF_CHANGE_INT_ENABLE_A, 8'h02);
        settle;
        rreg(OFF_INTERRUPT_CONTROL);
        check(rv, 8'h00);
        // Brown-out during a live port B pin seven change keeps the flag
        wreg(OFF_CHANGE_INT_ENABLE_B, 8'h80);
        @(posedge clk) pb7 <= 1'h1;
        @(posedge clk) bor <= 1'h1;
        @(posedge clk) bor <= 1'h0;
        rreg(OFF_INTERRUPT_CONTROL);
        check(rv, 8'h01);
        // One function per pin at a time, the unselected sources held low
        wreg(OFF_DIRECTION_C, 8'h00);
        for (int f = 0; f < 4; f++) begin
            wreg(OFF_PIN_FUNC_C, {4'h0, f[1:0], f[1:0]});
            cmp <= (f == 1);
            pwa <= (f == 2);
            pwb <= (f == 2);
            cco <= (f == 1);
            settle;
            check(8'(pc_out), (f == 1 || f == 2) ? 8'h03 : 8'h00);
        end
        end_sim;
    end
endmodule : port_pin_features_tb
